// file: verilog/ipd_pkg.sv
// constants, delay tables and state type of the ignition power delay controller
// Function
// - A four-bit switch picks one of sixteen modes, each fixing an on-delay and an off-delay for ignition changes.
// - Setting zero keeps the system always powered and ignores ignition, and is the factory default.
// - Settings two to four use no on-delay and off-delays of 5, 10 and 20 seconds.
// - Settings five to nine use a 5 second on-delay and off-delays of 30 s, 60 s, 90 s, 30 min and 1 hour.
// - Settings A to F use a 10 second on-delay and off-delays of 2, 4, 6, 8, 12 and 24 hours.
// - In every setting but zero the controller watches ignition and powers the system by the selected delay pair.
package ipd_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int NS_PER_SEC    = 1_000_000_000;
    localparam int NS_PER_MS     = 1_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int SEC_CYCLES    = TICK_PERIOD_S * NS_PER_SEC / CLK_PERIOD_NS;
    localparam int PULSE_MS      = 200;
    localparam int PULSE_CYCLES  = PULSE_MS * NS_PER_MS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // mode switch
    // ----------------------------------------------------------------
    localparam int           MODE_W      = 4;
    localparam logic [3:0]   MODE_ALWAYS = 4'h0;
    localparam logic [3:0]   MODE_DIRECT = 4'h1;
    localparam logic [3:0]   MODE_ON5    = 4'h5;
    localparam logic [3:0]   MODE_ON10   = 4'hA;

    // ----------------------------------------------------------------
    // delays in seconds, except OFF_30_MIN in minutes and the OFF_*_HR entries in hours
    // ----------------------------------------------------------------
    localparam int           DLY_W       = 17;
    localparam logic [16:0]  SEC_PER_MIN = 17'h0003C;
    localparam logic [16:0]  SEC_PER_HR  = 17'h00E10;
    localparam logic [16:0]  DLY_NONE    = 17'h00000;
    localparam logic [16:0]  ON_5_S      = 17'h00005;
    localparam logic [16:0]  ON_10_S     = 17'h0000A;
    localparam logic [16:0]  OFF_5_S     = 17'h00005;
    localparam logic [16:0]  OFF_10_S    = 17'h0000A;
    localparam logic [16:0]  OFF_20_S    = 17'h00014;
    localparam logic [16:0]  OFF_30_S    = 17'h0001E;
    localparam logic [16:0]  OFF_60_S    = 17'h0003C;
    localparam logic [16:0]  OFF_90_S    = 17'h0005A;
    localparam logic [16:0]  OFF_30_MIN  = 17'h0001E;
    localparam logic [16:0]  OFF_1_HR    = 17'h00001;
    localparam logic [16:0]  OFF_2_HR    = 17'h00002;
    localparam logic [16:0]  OFF_4_HR    = 17'h00004;
    localparam logic [16:0]  OFF_6_HR    = 17'h00006;
    localparam logic [16:0]  OFF_8_HR    = 17'h00008;
    localparam logic [16:0]  OFF_12_HR   = 17'h0000C;
    localparam logic [16:0]  OFF_24_HR   = 17'h00018;

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ON_WAIT  = 3'b001,
        ST_RUN      = 3'b010,
        ST_OFF_WAIT = 3'b011,
        ST_ALWAYS   = 3'b100
    } ipd_state_type;

    // ----------------------------------------------------------------
    // delay lookup
    // ----------------------------------------------------------------
    function automatic logic [16:0] on_delay_s(input logic [3:0] mode);
        if (mode >= MODE_ON10) begin
            on_delay_s = ON_10_S;
        end else if (mode >= MODE_ON5) begin
            on_delay_s = ON_5_S;
        end else begin
            on_delay_s = DLY_NONE;
        end
    endfunction

    function automatic logic [16:0] off_delay_s(input logic [3:0] mode);
        case (mode)
            4'h2:    off_delay_s = OFF_5_S;
            4'h3:    off_delay_s = OFF_10_S;
            4'h4:    off_delay_s = OFF_20_S;
            4'h5:    off_delay_s = OFF_30_S;
            4'h6:    off_delay_s = OFF_60_S;
            4'h7:    off_delay_s = OFF_90_S;
            4'h8:    off_delay_s = OFF_30_MIN * SEC_PER_MIN;
            4'h9:    off_delay_s = OFF_1_HR * SEC_PER_HR;
            4'hA:    off_delay_s = OFF_2_HR * SEC_PER_HR;
            4'hB:    off_delay_s = OFF_4_HR * SEC_PER_HR;
            4'hC:    off_delay_s = OFF_6_HR * SEC_PER_HR;
            4'hD:    off_delay_s = OFF_8_HR * SEC_PER_HR;
            4'hE:    off_delay_s = OFF_12_HR * SEC_PER_HR;
            4'hF:    off_delay_s = OFF_24_HR * SEC_PER_HR;
            default: off_delay_s = DLY_NONE;
        endcase
    endfunction

    function automatic logic is_on(input ipd_state_type st);
        is_on = (st == ST_RUN) || (st == ST_OFF_WAIT) || (st == ST_ALWAYS);
    endfunction

endpackage

// file: verilog/ipd_tick.sv
// one-second tick generator with restart
`timescale 1ns/1ns
module ipd_tick
    import ipd_pkg::*;
#(
    parameter int CYCLES = SEC_CYCLES
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_restart,
    output logic      o_tick
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_tick;

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    always_comb begin
        next_cnt  = cnt + W'(1);
        next_tick = 1'b0;
        if (i_restart) begin
            next_cnt = '0; // phase aligned to delay start
        end else if (cnt == LAST) begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt    <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            o_tick <= next_tick;
        end
    end
endmodule

// file: verilog/ipd_ctrl.sv
// ignition power delay controller: mode decode, delay timing and button pulse
`timescale 1ns/1ns
module ipd_ctrl
    import ipd_pkg::*;
#(
    parameter int SEC_CYC   = SEC_CYCLES,
    parameter int PULSE_CYC = PULSE_CYCLES
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_ignition_input,
    input  wire logic [3:0] i_mode_switch,
    output logic            o_button_pulse,
    output logic            o_system_on,
    output logic            o_delay_pending,
    output logic            o_ignition_ignored
);
    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYC - 1);

    ipd_state_type state;
    ipd_state_type next_state;
    logic [16:0]   delay_cnt;
    logic [16:0]   next_delay_cnt;
    logic [PW-1:0] pulse_cnt;
    logic [PW-1:0] next_pulse_cnt;
    logic          next_button_pulse;
    logic          load;
    logic          start;
    logic          tick;
    logic          busy;
    logic          ignition_input;
    logic [3:0]    mode;
    logic [16:0]   on_dly;
    logic [16:0]   off_dly;
    logic [PW-1:0] press_len;
    logic [PW-1:0] next_press_len;

    assign ignition_input     = i_ignition_input;
    assign mode    = i_mode_switch;
    assign busy    = o_button_pulse;
    assign on_dly  = on_delay_s(mode);
    assign off_dly = off_delay_s(mode);

    // ----------------------------------------------------------------
    // second tick
    // ----------------------------------------------------------------
    ipd_tick #(
        .CYCLES (SEC_CYC)
    ) u_tick (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_restart (load),
        .o_tick    (tick)
    );

    // ----------------------------------------------------------------
    // sequencer next state
    // ----------------------------------------------------------------
    // a new press waits for the previous one to end so the host never
    // sees two requests merged into a single long press
    always_comb begin
        next_state     = state;
        next_delay_cnt = delay_cnt;
        load           = 1'b0;
        start          = 1'b0;
        if (mode == MODE_ALWAYS) begin
            if (state != ST_ALWAYS && !busy) begin
                next_state = ST_ALWAYS;
                start      = !is_on(state);
            end
        end else begin
            case (state)
                ST_IDLE: begin
                    if (ignition_input && !busy) begin
                        if (on_dly == DLY_NONE) begin
                            next_state = ST_RUN;
                            start      = 1'b1;
                        end else begin
                            next_state     = ST_ON_WAIT;
                            next_delay_cnt = on_dly;
                            load           = 1'b1;
                        end
                    end
                end
                ST_ON_WAIT: begin
                    if (!ignition_input) begin
                        next_state = ST_IDLE;
                    end else if (delay_cnt == DLY_NONE) begin
                        if (!busy) begin
                            next_state = ST_RUN;
                            start      = 1'b1;
                        end
                    end else if (tick) begin
                        next_delay_cnt = delay_cnt - 17'h00001;
                    end
                end
                ST_RUN, ST_ALWAYS: begin
                    if (ignition_input) begin
                        next_state = ST_RUN;
                    end else if (!busy) begin
                        if (off_dly == DLY_NONE) begin
                            next_state = ST_IDLE;
                            start      = 1'b1;
                        end else begin
                            next_state     = ST_OFF_WAIT;
                            next_delay_cnt = off_dly;
                            load           = 1'b1;
                        end
                    end
                end
                ST_OFF_WAIT: begin
                    if (ignition_input) begin
                        next_state = ST_RUN;
                    end else if (delay_cnt == DLY_NONE) begin
                        if (!busy) begin
                            next_state = ST_IDLE;
                            start      = 1'b1;
                        end
                    end else if (tick) begin
                        next_delay_cnt = delay_cnt - 17'h00001;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // button pulse next value
    // ----------------------------------------------------------------
    always_comb begin
        next_pulse_cnt    = pulse_cnt;
        next_button_pulse = 1'b0;
        if (start) begin
            next_pulse_cnt    = PULSE_LOAD;
            next_button_pulse = 1'b1;
        end else if (pulse_cnt != '0) begin
            next_pulse_cnt    = pulse_cnt - PW'(1);
            next_button_pulse = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state              <= ST_IDLE;
            delay_cnt          <= DLY_NONE;
            pulse_cnt          <= '0;
            o_button_pulse     <= 1'b0;
            o_system_on        <= 1'b0;
            o_delay_pending    <= 1'b0;
            o_ignition_ignored <= 1'b0;
        end else begin
            state              <= next_state;
            delay_cnt          <= next_delay_cnt;
            pulse_cnt          <= next_pulse_cnt;
            o_button_pulse     <= next_button_pulse;
            o_system_on        <= is_on(next_state);
            o_delay_pending    <= (next_state == ST_ON_WAIT) || (next_state == ST_OFF_WAIT);
            o_ignition_ignored <= (next_state == ST_ALWAYS);
        end
    end

    // ----------------------------------------------------------------
    // press length helper
    // ----------------------------------------------------------------
    // a repetition count cannot span a real press, so the width is counted
    always_comb begin
        next_press_len = '0;
        if (o_button_pulse) begin
            next_press_len = press_len + PW'(1);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            press_len <= '0;
        end else begin
            press_len <= next_press_len;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    always_mode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(o_ignition_ignored) && !$past(o_system_on) |-> $rose(o_button_pulse))
        else $error("always mode entered from off without a start press");

    direct_on_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state == ST_IDLE && ignition_input && mode == MODE_DIRECT && !busy |=> state == ST_RUN && o_button_pulse)
        else $error("direct mode did not switch on at once");

    direct_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state == ST_RUN && !ignition_input && mode == MODE_DIRECT && !busy |=> state == ST_IDLE && o_button_pulse)
        else $error("direct mode did not switch off at once");

    on_load_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state == ST_IDLE && ignition_input && mode >= MODE_ON5 && !busy
        |=> state == ST_ON_WAIT && delay_cnt == on_delay_s($past(mode)) && !o_button_pulse)
        else $error("on delay not loaded from the mode");

    off_load_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state == ST_RUN && !ignition_input && mode > MODE_DIRECT && !busy
        |=> state == ST_OFF_WAIT && delay_cnt == off_delay_s($past(mode)) && o_system_on)
        else $error("off delay not loaded from the mode");

    cancel_on_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state == ST_ON_WAIT && !ignition_input && mode != MODE_ALWAYS |=> state == ST_IDLE && !$rose(o_button_pulse))
        else $error("pending power on not cancelled");

    cancel_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state == ST_OFF_WAIT && ignition_input && mode != MODE_ALWAYS |=> state == ST_RUN && !$rose(o_button_pulse))
        else $error("pending power off not cancelled");

    wait_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state == ST_ON_WAIT && ignition_input && delay_cnt != DLY_NONE && mode != MODE_ALWAYS
        |=> state == ST_ON_WAIT && delay_cnt >= $past(delay_cnt) - 17'h00001)
        else $error("on delay left early");

    off_expire_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        state == ST_OFF_WAIT && !ignition_input && delay_cnt == DLY_NONE && mode != MODE_ALWAYS && !busy
        |=> state == ST_IDLE && $rose(o_button_pulse) && !o_system_on)
        else $error("expired off delay gave no shutdown press");

    pulse_width_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(o_button_pulse) |-> o_button_pulse [*2])
        else $error("button press too short");

    press_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_button_pulse && press_len != PULSE_LOAD |=> o_button_pulse)
        else $error("button press ended early");

    press_end_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_button_pulse && press_len == PULSE_LOAD |=> !o_button_pulse)
        else $error("button press held too long");
endmodule

// file: test/ipd_host_model.sv
// host platform model: power state toggled by each button press
`timescale 1ns/1ns
module ipd_host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_button_pulse,
    output logic      o_host_on,
    output int        o_press_count,
    output int        o_last_width
);
    int run_len;

    // ----------------------------------------------------------------
    // power button
    // ----------------------------------------------------------------
    // acts on release, as a real button handler does; width kept for the bench
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_host_on     <= 1'b0;
            o_press_count <= 0;
            o_last_width  <= 0;
            run_len       <= 0;
        end else if (i_button_pulse) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            o_host_on     <= !o_host_on;
            o_press_count <= o_press_count + 1;
            o_last_width  <= run_len;
            run_len       <= 0;
        end
    end
endmodule

// file: test/testbench.sv
// self-checking bench of the ignition power delay controller
`timescale 1ns/1ns
module testbench;
    import ipd_pkg::*;
    localparam int SC = 20;
    localparam int PC = 4;

    logic       i_clk_sys;
    logic       i_rst;
    logic       i_ignition_input;
    logic [3:0] i_mode_switch;
    logic       o_button_pulse;
    logic       o_system_on;
    logic       o_delay_pending;
    logic       o_ignition_ignored;
    logic       host_on;
    int         press_count;
    int         last_width;
    int         failures;
    int         checks_done;

    // ----------------------------------------------------------------
    // design and host
    // ----------------------------------------------------------------
    ipd_ctrl #(.SEC_CYC(SC), .PULSE_CYC(PC)) DUT (
        .i_clk_sys          (i_clk_sys),
        .i_rst              (i_rst),
        .i_ignition_input   (i_ignition_input),
        .i_mode_switch      (i_mode_switch),
        .o_button_pulse     (o_button_pulse),
        .o_system_on        (o_system_on),
        .o_delay_pending    (o_delay_pending),
        .o_ignition_ignored (o_ignition_ignored)
    );

    ipd_host_model u_host (
        .i_clk_sys      (i_clk_sys),
        .i_rst          (i_rst),
        .i_button_pulse (o_button_pulse),
        .o_host_on      (host_on),
        .o_press_count  (press_count),
        .o_last_width   (last_width)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s is %b", $time, what, got);
        end
    endtask

    task automatic chk_num(input int got, input int lo, input int hi, input string what);
        checks_done++;
        if (got < lo || got > hi) begin
            failures++;
            $display("Error at %0t: %s is %0d", $time, what, got);
        end
    endtask

    task automatic drive(input logic ignition_input, input logic [3:0] mode);
        @(negedge i_clk_sys);
        i_ignition_input = ignition_input;
        i_mode_switch    = mode;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    // delay counted from the input change; host state checked after release
    task automatic press_after(input int dly_s, input logic exp_on);
        int cyc;
        cyc = 0;
        while (o_button_pulse !== 1'b1 && cyc < dly_s * SC + 10) begin
            @(negedge i_clk_sys);
            cyc++;
        end
        chk_num(cyc, dly_s * SC - 1, dly_s * SC + 3, "press delay");
        cyc = 0;
        while (o_button_pulse !== 1'b0 && cyc < PC + 10) begin
            @(negedge i_clk_sys);
            cyc++;
        end
        if (o_button_pulse !== 1'b0 || cyc == 0) begin
            failures++;
            $display("Error at %0t: press missing or stuck", $time);
            wrap_up();
        end
        idle(1);
        chk_num(last_width, PC, PC, "press width");
        chk_bit(o_system_on, exp_on, "system on");
        chk_bit(host_on, exp_on, "host on");
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic sc_reset_state();
        chk_bit(o_system_on, 1'b0, "on after reset");
        chk_bit(o_delay_pending, 1'b0, "pending after reset");
        chk_bit(o_button_pulse, 1'b0, "press after reset");
    endtask

    task automatic sc_direct();
        drive(1'b1, 4'h1);
        press_after(0, 1'b1);
        drive(1'b0, 4'h1);
        press_after(0, 1'b0);
    endtask

    // every short mode timed in both directions
    task automatic sc_short_modes();
        int on_s[6];
        int off_s[6];
        on_s  = '{0, 0, 0, 5, 5, 5};
        off_s = '{5, 10, 20, 30, 60, 90};
        for (int k = 0; k < 6; k++) begin
            drive(1'b1, 4'(k + 2));
            press_after(on_s[k], 1'b1);
            drive(1'b0, 4'(k + 2));
            idle(1);
            chk_bit(o_delay_pending, 1'b1, "off pending");
            press_after(off_s[k], 1'b0);
        end
    endtask

    // long off-delays outlast 91 s, then are cancelled by ignition return
    task automatic sc_long_modes();
        int pc;
        drive(1'b1, 4'hA);
        press_after(10, 1'b1);
        for (int m = 8; m < 16; m++) begin
            pc = press_count;
            drive(1'b0, 4'(m));
            idle(91 * SC);
            chk_bit(o_delay_pending, 1'b1, "long pending");
            chk_num(press_count, pc, pc, "early press");
            drive(1'b1, 4'(m));
            idle(2);
            chk_bit(o_delay_pending, 1'b0, "cancel off");
            chk_bit(o_system_on, 1'b1, "stays on");
        end
        drive(1'b0, 4'h1);
        press_after(0, 1'b0);
    endtask

    task automatic sc_cancel_on();
        int pc;
        drive(1'b1, 4'h5);
        idle(2 * SC);
        chk_bit(o_delay_pending, 1'b1, "on pending");
        drive(1'b0, 4'h5);
        idle(2);
        chk_bit(o_delay_pending, 1'b0, "cancel on");
        pc = press_count;
        idle(6 * SC);
        chk_num(press_count, pc, pc, "cancelled press");
        drive(1'b1, 4'h5);
        press_after(5, 1'b1);
        drive(1'b0, 4'h1);
        press_after(0, 1'b0);
    endtask

    // ignition toggles while always powered must not press
    task automatic sc_always();
        int pc;
        drive(1'b0, 4'h0);
        press_after(0, 1'b1);
        chk_bit(o_ignition_ignored, 1'b1, "ignored");
        pc = press_count;
        for (int k = 0; k < 4; k++) begin
            drive(k[0] == 1'b0, 4'h0);
            idle(3 * SC);
        end
        chk_num(press_count, pc, pc, "press in mode 0");
        chk_bit(o_system_on, 1'b1, "on in mode 0");
        drive(1'b1, 4'h1);
        idle(3);
        chk_bit(o_ignition_ignored, 1'b0, "left mode 0");
        chk_num(press_count, pc, pc, "press on leave");
        drive(1'b0, 4'h1);
        press_after(0, 1'b0);
    endtask

    initial begin
        failures         = 0;
        checks_done      = 0;
        i_rst            = 1'b1;
        i_ignition_input = 1'b0;
        i_mode_switch    = 4'h1;
        idle(6);
        i_rst = 1'b0;
        idle(2);
        sc_reset_state();
        sc_direct();
        sc_short_modes();
        sc_cancel_on();
        sc_long_modes();
        sc_always();
        wrap_up();
    end
endmodule
